/* core/sensor_irq_wake_router.sv */
// Overview of operation
// - With buffer hold off, any wake/sleep change flushes the sample buffer.
// - With buffer hold on, a mode change keeps the buffer and blocks new samples until emptied.
// - A sample arriving while held and not yet emptied raises the hold error, kept till emptied.
// - Emptying the buffer clears the hold error.
// - Wake bits 6..3 let transient, orientation, pulse, fall/motion events wake from sleep.
// - Polarity bit 1 selects active-low (0) or active-high (1) interrupt pins.
// - Drive bit 0 selects push-pull (0) or open-drain (1) interrupt pins.
// - A source event reaches the pins only while its enable bit is set.
// - Enable bits: autosleep 7, fifo 6, transient 5, orientation 4, pulse 3, fall 2, ready 0.
// - Routing bit 0 sends a source to pin b, 1 to pin a, all reset to 0.
// - Routing uses the same bit positions as enables and serves both pins.
// - With autosleep irq enabled, each wake/sleep change raises the autosleep event.
// - Software reset returns all three registers to defaults.
`timescale 1ns/1ps
module sensor_irq_wake_router
  import sensor_irq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic soft_reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // function block event flags, bit 7 and bit 1 unused here
  input wire logic [sensor_irq_pkg::SOURCE_COUNT-1:0] event_flags,
  input wire logic autosleep_ack,
  // system mode and sample buffer
  input wire logic sleep_mode,
  input wire logic sample_strobe,
  input wire logic fifo_empty,
  output logic fifo_flush,
  output logic fifo_input_block,
  output logic buffer_hold_error,
  output logic autosleep_pending,
  output logic wake_request,
  // interrupt pads
  output logic irq_pin_a_out,
  output logic irq_pin_a_oe,
  output logic irq_pin_b_out,
  output logic irq_pin_b_oe
);

  import sensor_irq_pkg::*;

  logic [7:0] wake_and_pin_config;
  logic [7:0] irq_enable;
  logic [7:0] irq_routing;
  logic clear_all;
  logic mode_prev;
  logic mode_seen;
  logic mode_change;
  logic [SOURCE_COUNT-1:0] sources;
  logic [SOURCE_COUNT-1:0] gated;
  logic [PIN_COUNT-1:0] pin_active;
  logic [PIN_COUNT-1:0] pin_out;
  logic [PIN_COUNT-1:0] pin_oe;
  logic [3:0] wake_hits;
  gate_state_t gate_state;
  gate_state_t next_gate_state;

  // write mask for an address, zero where nothing is mapped
  function automatic logic [7:0] writable(input logic [7:0] addr);
    case (addr)
      WAKE_AND_PIN_CONFIG_ADDR: writable = WAKE_AND_PIN_CONFIG_MASK;
      IRQ_ENABLE_ADDR: writable = IRQ_SOURCE_MASK;
      IRQ_ROUTING_ADDR: writable = IRQ_SOURCE_MASK;
      default: writable = 8'h00;
    endcase
  endfunction

  assign clear_all = reset | soft_reset;

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge ref_clk) begin
    if (clear_all) begin
      wake_and_pin_config <= WAKE_AND_PIN_CONFIG_RESET;
    end else if (clk_en && reg_wr && reg_addr == WAKE_AND_PIN_CONFIG_ADDR) begin
      wake_and_pin_config <= reg_wdata & writable(reg_addr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear_all) begin
      irq_enable <= IRQ_ENABLE_RESET;
    end else if (clk_en && reg_wr && reg_addr == IRQ_ENABLE_ADDR) begin
      irq_enable <= reg_wdata & writable(reg_addr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clear_all) begin
      irq_routing <= IRQ_ROUTING_RESET;
    end else if (clk_en && reg_wr && reg_addr == IRQ_ROUTING_ADDR) begin
      irq_routing <= reg_wdata & writable(reg_addr);
    end
  end

  // read data held in a flop, unmapped addresses give zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= UNMAPPED_READ;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        WAKE_AND_PIN_CONFIG_ADDR: reg_rdata <= wake_and_pin_config;
        IRQ_ENABLE_ADDR: reg_rdata <= irq_enable;
        IRQ_ROUTING_ADDR: reg_rdata <= irq_routing;
        default: reg_rdata <= UNMAPPED_READ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system mode change; first sample after reset only primes the history
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_prev <= 1'b0;
      mode_seen <= 1'b0;
    end else if (clk_en) begin
      mode_prev <= sleep_mode;
      mode_seen <= 1'b1;
    end
  end

  assign mode_change = mode_seen && (sleep_mode != mode_prev);

  // autosleep event, a change in the same cycle as the ack wins
  always_ff @(posedge ref_clk) begin
    if (clear_all) begin
      autosleep_pending <= 1'b0;
    end else if (clk_en) begin
      if (mode_change && irq_enable[AUTOSLEEP_SRC]) begin
        autosleep_pending <= 1'b1;
      end else if (autosleep_ack) begin
        autosleep_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer gate
  always_comb begin
    next_gate_state = gate_state;
    case (gate_state)
      GATE_OPEN: begin
        // an already empty buffer has nothing to keep, so no hold is taken
        if (mode_change && wake_and_pin_config[BUFFER_HOLD_BIT] && !fifo_empty) begin
          next_gate_state = GATE_HELD;
        end
      end
      GATE_HELD: begin
        if (fifo_empty) begin
          next_gate_state = GATE_OPEN;
        end else if (sample_strobe) begin
          next_gate_state = GATE_ERROR;
        end
      end
      GATE_ERROR: begin
        if (fifo_empty) begin
          next_gate_state = GATE_OPEN;
        end
      end
      default: next_gate_state = GATE_OPEN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (clear_all) begin
      gate_state <= GATE_OPEN;
    end else if (clk_en) begin
      gate_state <= next_gate_state;
    end
  end

  assign fifo_input_block = (gate_state != GATE_OPEN);
  assign buffer_hold_error = (gate_state == GATE_ERROR);

  // one-cycle flush pulse; never while the buffer hold bit is set, even if the gate is still held
  always_ff @(posedge ref_clk) begin
    if (clear_all) begin
      fifo_flush <= 1'b0;
    end else if (clk_en) begin
      fifo_flush <= mode_change && !wake_and_pin_config[BUFFER_HOLD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake path, only enabled interrupts can wake
  assign wake_hits = wake_and_pin_config[TRANSIENT_WAKE_BIT:FALL_MOTION_WAKE_BIT]
                   & gated[TRANSIENT_SRC:FALL_MOTION_SRC];

  always_ff @(posedge ref_clk) begin
    if (clear_all) begin
      wake_request <= 1'b0;
    end else if (clk_en) begin
      wake_request <= sleep_mode && (|wake_hits);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gating and routing to the pins
  always_comb begin
    sources = event_flags;
    sources[AUTOSLEEP_SRC] = autosleep_pending;
  end

  assign gated = sources & irq_enable & IRQ_SOURCE_MASK;
  assign pin_active[PIN_A] = |(gated & irq_routing);
  assign pin_active[PIN_B] = |(gated & ~irq_routing & IRQ_SOURCE_MASK);

  // host still has to read the source flags to tell sharing causes apart
  generate
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
      irq_pin_driver u_pin (
        .ref_clk(ref_clk),
        .reset(clear_all),
        .clk_en(clk_en),
        .pin_active(pin_active[p]),
        .active_high(wake_and_pin_config[IRQ_POLARITY_BIT]),
        .open_drain(wake_and_pin_config[IRQ_DRIVE_MODE_BIT]),
        .pin_out(pin_out[p]),
        .pin_oe(pin_oe[p])
      );
    end
  endgenerate

  assign irq_pin_a_out = pin_out[PIN_A];
  assign irq_pin_a_oe = pin_oe[PIN_A];
  assign irq_pin_b_out = pin_out[PIN_B];
  assign irq_pin_b_oe = pin_oe[PIN_B];

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (clear_all);

  property p_flush;
    clk_en && mode_change && !wake_and_pin_config[BUFFER_HOLD_BIT] |=> fifo_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush missing");

  property p_hold;
    clk_en && mode_change && wake_and_pin_config[BUFFER_HOLD_BIT] && !fifo_empty
      && !fifo_input_block |=> fifo_input_block && !fifo_flush;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not taken");

  property p_err_set;
    clk_en && fifo_input_block && sample_strobe && !fifo_empty |=> buffer_hold_error;
  endproperty
  a_err_set: assert property (p_err_set) else $error("hold error missing");

  property p_err_clr;
    clk_en && fifo_empty |=> !buffer_hold_error && !fifo_input_block;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("hold error kept");

  property p_wake;
    clk_en && sleep_mode && (|wake_hits) |=> wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing");

  property p_polarity;
    clk_en && pin_active[PIN_A] && !wake_and_pin_config[IRQ_DRIVE_MODE_BIT]
      |=> irq_pin_a_oe && (irq_pin_a_out == $past(wake_and_pin_config[IRQ_POLARITY_BIT]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin a polarity");

  property p_open_drain;
    clk_en && wake_and_pin_config[IRQ_DRIVE_MODE_BIT] |=> !irq_pin_a_out && !irq_pin_b_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drives high");

  property p_masked;
    clk_en && irq_enable == 8'h00 && !wake_and_pin_config[IRQ_DRIVE_MODE_BIT]
      |=> irq_pin_b_out == !$past(wake_and_pin_config[IRQ_POLARITY_BIT]);
  endproperty
  a_masked: assert property (p_masked) else $error("disabled source on pin");

  property p_route;
    clk_en && (|(gated & ~irq_routing & IRQ_SOURCE_MASK)) && (gated & irq_routing) == 8'h00
      && !wake_and_pin_config[IRQ_DRIVE_MODE_BIT] |=> irq_pin_a_out != irq_pin_b_out;
  endproperty
  a_route: assert property (p_route) else $error("routing to wrong pin");

  property p_autosleep;
    clk_en && mode_change && irq_enable[AUTOSLEEP_SRC] |=> autosleep_pending;
  endproperty
  a_autosleep: assert property (p_autosleep) else $error("autosleep event lost");

  property p_soft_reset;
    @(posedge ref_clk) disable iff (reset) clk_en && soft_reset |=> wake_and_pin_config == 8'h00
      && irq_enable == 8'h00 && irq_routing == 8'h00;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

  property p_unused;
    wake_and_pin_config[2] == 1'b0 && irq_enable[1] == 1'b0 && irq_routing[1] == 1'b0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");

endmodule // sensor_irq_wake_router

/* core/sensor_irq_pkg.sv */
package sensor_irq_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] WAKE_AND_PIN_CONFIG_ADDR = 8'h2C;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h2D;
  localparam logic [7:0] IRQ_ROUTING_ADDR = 8'h2E;

  // values after reset
  localparam logic [7:0] WAKE_AND_PIN_CONFIG_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_ROUTING_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // writable bits; unused positions stay zero
  localparam logic [7:0] WAKE_AND_PIN_CONFIG_MASK = 8'hFB;
  localparam logic [7:0] IRQ_SOURCE_MASK = 8'hFD;

  // wake_and_pin_config fields
  localparam int BUFFER_HOLD_BIT = 7;
  localparam int TRANSIENT_WAKE_BIT = 6;
  localparam int ORIENTATION_WAKE_BIT = 5;
  localparam int PULSE_WAKE_BIT = 4;
  localparam int FALL_MOTION_WAKE_BIT = 3;
  localparam int IRQ_POLARITY_BIT = 1;
  localparam int IRQ_DRIVE_MODE_BIT = 0;

  // source positions, shared by irq_enable and irq_routing
  localparam int AUTOSLEEP_SRC = 7;
  localparam int FIFO_SRC = 6;
  localparam int TRANSIENT_SRC = 5;
  localparam int ORIENTATION_SRC = 4;
  localparam int PULSE_SRC = 3;
  localparam int FALL_MOTION_SRC = 2;
  localparam int SAMPLE_READY_SRC = 0;

  localparam int SOURCE_COUNT = 8;
  localparam int PIN_COUNT = 2;
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;

  // buffer gate states, gray coded along open, held, error
  typedef enum logic [1:0] {
    GATE_OPEN = 2'b00,
    GATE_HELD = 2'b01,
    GATE_ERROR = 2'b11
  } gate_state_t;

endpackage

/* core/irq_pin_driver.sv */
`timescale 1ns/1ps
module irq_pin_driver (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // control
  input wire logic pin_active,
  input wire logic active_high,
  input wire logic open_drain,
  // pad
  output logic pin_out,
  output logic pin_oe
);

  logic level;

  // level the line should carry
  assign level = active_high ? pin_active : ~pin_active;

  ////////////////////////////////////////////////////////////////////////
  // open drain only ever pulls low, so a high level means release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_out <= 1'b1;
      pin_oe <= 1'b1;
    end else if (clk_en) begin
      pin_out <= open_drain ? 1'b0 : level;
      pin_oe <= ~open_drain | ~level;
    end
  end

endmodule // irq_pin_driver

/* sim/irq_host_model.sv */
`timescale 1ns/1ps
module irq_host_model #(
  parameter int ACK_DELAY = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // interrupt pads and status
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  input wire logic autosleep_pending,
  // host side
  output logic autosleep_ack,
  output logic wire_a,
  output logic wire_b
);
  logic [3:0] wait_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // released open-drain line floats to the pull-up level
  assign wire_a = pin_a_oe ? pin_a_out : 1'h1;
  assign wire_b = pin_b_oe ? pin_b_out : 1'h1;
  ////////////////////////////////////////////////////////////////////////////
  // slow source read; never acks twice in a row, so a fresh event is not lost
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_cnt <= 4'h0;
      autosleep_ack <= 1'h0;
    end else begin
      autosleep_ack <= autosleep_pending && !autosleep_ack && wait_cnt == ACK_DELAY[3:0];
      wait_cnt <= (autosleep_pending && !autosleep_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // irq_host_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import sensor_irq_pkg::*;
  typedef struct {string nm; logic [7:0] v;} note_t;
  logic ref_clk, reset, clk_en, soft_reset, reg_wr, reg_rd, autosleep_ack;
  logic sleep_mode, sample_strobe, fifo_empty, fifo_flush, fifo_input_block;
  logic buffer_hold_error, autosleep_pending, wake_request, rd_q;
  logic pa_out, pa_oe, pb_out, pb_oe, wire_a, wire_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, event_flags, k, n;
  logic [31:0] seed;
  int n_fail, num_checks, cycles;
  note_t notes[$];
  note_t nt;
  ////////////////////////////////////////////////////////////////////////////
  sensor_irq_wake_router i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .soft_reset(soft_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_flags(event_flags),
    .autosleep_ack(autosleep_ack), .sleep_mode(sleep_mode), .sample_strobe(sample_strobe),
    .fifo_empty(fifo_empty), .fifo_flush(fifo_flush), .fifo_input_block(fifo_input_block),
    .buffer_hold_error(buffer_hold_error), .autosleep_pending(autosleep_pending),
    .wake_request(wake_request), .irq_pin_a_out(pa_out), .irq_pin_a_oe(pa_oe),
    .irq_pin_b_out(pb_out), .irq_pin_b_oe(pb_oe));
  irq_host_model i_host (.ref_clk(ref_clk), .reset(reset), .pin_a_out(pa_out),
    .pin_a_oe(pa_oe), .pin_b_out(pb_out), .pin_b_oe(pb_oe),
    .autosleep_pending(autosleep_pending), .autosleep_ack(autosleep_ack),
    .wire_a(wire_a), .wire_b(wire_b));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  // expected read data goes on the queue; the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    notes.push_back('{"rdata", e});
    @(posedge ref_clk);
    reg_rd <= 1'h0;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // read data is valid one cycle after the strobe was taken
  always @(posedge ref_clk) begin
    if (rd_q && notes.size() > 0) begin
      nt = notes.pop_front();
      chk(nt.nm, reg_rdata, nt.v);
    end
    rd_q <= reg_rd;
  end
  // hang guard, far above the expected run of some 220 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'h1;
    clk_en = 1'h1;
    soft_reset = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    event_flags = 8'h00;
    sleep_mode = 1'h0;
    sample_strobe = 1'h0;
    fifo_empty = 1'h1;
    seed = 32'h30A69452;
    repeat (16) @(posedge ref_clk);
    reset <= 1'h0;
    rd(WAKE_AND_PIN_CONFIG_ADDR, 8'h00);
    rd(IRQ_ENABLE_ADDR, 8'h00);
    rd(IRQ_ROUTING_ADDR, 8'h00);
    tick(1);
    chk("idle_pins", {4'h0, pa_out, pa_oe, pb_out, pb_oe}, 8'h0F);
    wr(WAKE_AND_PIN_CONFIG_ADDR, 8'hFF);
    wr(IRQ_ENABLE_ADDR, 8'hFF);
    wr(IRQ_ROUTING_ADDR, 8'hFF);
    wr(8'h2F, 8'h5A);
    rd(WAKE_AND_PIN_CONFIG_ADDR, 8'hFB);
    rd(IRQ_ENABLE_ADDR, 8'hFD);
    rd(IRQ_ROUTING_ADDR, 8'hFD);
    rd(8'h2F, UNMAPPED_READ);
    @(posedge ref_clk);
    soft_reset <= 1'h1;
    @(posedge ref_clk);
    soft_reset <= 1'h0;
    rd(WAKE_AND_PIN_CONFIG_ADDR, 8'h00);
    rd(IRQ_ENABLE_ADDR, 8'h00);
    rd(IRQ_ROUTING_ADDR, 8'h00);
    // a write while the clock enable is low must not land
    @(posedge ref_clk);
    clk_en <= 1'h0;
    wr(IRQ_ENABLE_ADDR, 8'hFF);
    @(posedge ref_clk);
    clk_en <= 1'h1;
    rd(IRQ_ENABLE_ADDR, 8'h00);
    // one source at a time, random pin, noise on the ignored flag bits
    for (int s = 0; s < 7; s++) begin
      if (s == 1) continue;
      seed = xs(seed);
      k = 8'h01 << s;
      wr(IRQ_ENABLE_ADDR, k);
      wr(IRQ_ROUTING_ADDR, seed[7:0] & IRQ_SOURCE_MASK);
      @(posedge ref_clk);
      event_flags <= k | (seed[15:8] & 8'h82);
      tick(2);
      chk("pin_a", {7'h0, wire_a}, {7'h0, ~seed[s]});
      chk("pin_b", {7'h0, wire_b}, {7'h0, seed[s]});
      wr(IRQ_ENABLE_ADDR, 8'h00);
      tick(2);
      chk("pins_disabled", {6'h0, wire_a, wire_b}, 8'h03);
      @(posedge ref_clk);
      event_flags <= 8'h00;
    end
    // every polarity and drive mode, event off and on
    wr(IRQ_ENABLE_ADDR, 8'h01);
    wr(IRQ_ROUTING_ADDR, 8'h01);
    for (int m = 0; m < 8; m++) begin
      wr(WAKE_AND_PIN_CONFIG_ADDR, {6'h0, m[1:0]});
      @(posedge ref_clk);
      event_flags <= {7'h0, m[2]};
      tick(2);
      chk("level_a", {7'h0, wire_a}, {7'h0, ~(m[2] ^ m[1])});
      chk("oe_a", {7'h0, pa_oe}, {7'h0, ~m[0] | (m[2] ^ m[1])});
    end
    @(posedge ref_clk);
    event_flags <= 8'h00;
    wr(WAKE_AND_PIN_CONFIG_ADDR, 8'h00);
    wr(IRQ_ENABLE_ADDR, 8'h80);
    wr(IRQ_ROUTING_ADDR, 8'h80);
    @(posedge ref_clk);
    sleep_mode <= 1'h1;
    n = 8'h00;
    repeat (4) begin
      tick(1);
      n = n + {7'h0, fifo_flush};
    end
    chk("flush_count", n, 8'h01);
    chk("autosleep", {6'h0, autosleep_pending, wire_a}, 8'h02);
    tick(12);
    chk("autosleep_acked", {7'h0, autosleep_pending}, 8'h00);
    // hold: mode change blocks input, late sample flags the error
    wr(WAKE_AND_PIN_CONFIG_ADDR, 8'h80);
    @(posedge ref_clk);
    fifo_empty <= 1'h0;
    sleep_mode <= 1'h0;
    tick(2);
    chk("block", {6'h0, fifo_input_block, fifo_flush}, 8'h02);
    chk("autosleep_wake", {7'h0, autosleep_pending}, 8'h01);
    @(posedge ref_clk);
    sample_strobe <= 1'h1;
    @(posedge ref_clk);
    sample_strobe <= 1'h0;
    tick(2);
    chk("hold_error", {6'h0, buffer_hold_error, fifo_input_block}, 8'h03);
    @(posedge ref_clk);
    fifo_empty <= 1'h1;
    tick(2);
    chk("hold_clear", {6'h0, buffer_hold_error, fifo_input_block}, 8'h00);
    // wake from sleep by fall/motion, then bypassed
    wr(WAKE_AND_PIN_CONFIG_ADDR, 8'h08);
    wr(IRQ_ENABLE_ADDR, 8'h04);
    @(posedge ref_clk);
    sleep_mode <= 1'h1;
    event_flags <= 8'h04;
    tick(3);
    chk("wake", {6'h0, autosleep_pending, wake_request}, 8'h01);
    wr(WAKE_AND_PIN_CONFIG_ADDR, 8'h00);
    tick(2);
    chk("wake_bypass", {7'h0, wake_request}, 8'h00);
    tick(4);
    end_sim();
  end
endmodule // tb_top
